// File: design/pwl_pkg.sv
// shared constants and types of the phy word configuration loader
package pwl_pkg;

    localparam int NUM_PORTS = 4;
    localparam int NUM_REGS  = 12;
    localparam int NUM_WORDS = 18;
    localparam int AVM_AW    = 11;

    // configuration-space offsets of the per-port target registers
    localparam logic [7:0] OFS_DESKEW = 8'h68;
    localparam logic [7:0] OFS_PHY0   = 8'h74;
    localparam logic [7:0] OFS_PHY1   = 8'h78;
    localparam logic [7:0] OFS_PHY2   = 8'h7C;
    localparam logic [7:0] OFS_XPORT4 = 8'h84;
    localparam logic [7:0] OFS_XPORT5 = 8'h88;
    localparam logic [7:0] OFS_TLCTRL = 8'h8C;
    localparam logic [7:0] OFS_PHY3   = 8'h90;
    localparam logic [7:0] OFS_MARGIN = 8'h94;
    localparam logic [7:0] OFS_BUFCTL = 8'h98;
    localparam logic [7:0] OFS_CAP    = 8'hE4;
    localparam logic [7:0] OFS_DEEMPH = 8'hF0;

    // storage index of each target register
    localparam int I_DESKEW = 0, I_PHY0 = 1, I_PHY1 = 2, I_PHY2 = 3, I_XPORT4 = 4;
    localparam int I_XPORT5 = 5, I_TLCTRL = 6, I_PHY3 = 7, I_MARGIN = 8, I_BUFCTL = 9;
    localparam int I_CAP = 10, I_DEEMPH = 11;

    localparam logic [31:0] CFG_RESET = 32'h0000_0000;

    // word addresses in the store
    localparam logic [7:0] W_MARGIN    = 8'h0E;
    localparam logic [7:0] W_PHY0      = 8'h10;
    localparam logic [7:0] W_PHY1      = 8'h12;
    localparam logic [7:0] W_PHY2      = 8'h14;
    localparam logic [7:0] W_X4LO      = 8'h16;
    localparam logic [7:0] W_X4HI      = 8'h18;
    localparam logic [7:0] W_X5LO      = 8'h1A;
    localparam logic [7:0] W_X5HI      = 8'h1C;
    localparam logic [7:0] W_DELTA     = 8'h1E;
    localparam logic [7:0] W_PORT_BASE = 8'h20;
    localparam logic [7:0] W_PORT_LAST = 8'h26;
    localparam logic [7:0] W_P2_BASE   = 8'h30;
    localparam logic [7:0] W_P2_LAST   = 8'h36;
    localparam logic [7:0] W_PORT0     = 8'h40;
    localparam logic [7:0] WORD_STEP   = 8'h02;
    localparam int SEQ_COMMON = 9;
    localparam int SEQ_PORT   = 4;

    // field positions: WB_ in the word, the rest in the target register
    localparam int DRV_W = 5, WB_LO = 0, WB_MID = 5, WB_HI = 10, WB_TOP = 15;
    localparam int CAP_OBFF = 18, NOM_LSB = 16, TL_GEN2 = 31, EMP_LSB = 16, TL_X6B0 = 16;
    localparam int LAT_LSB = 0, LAT_W = 4, RXDET_LSB = 4, RXDET_W = 3;
    localparam int WB_HALFD = 7, HALFD_LSB = 15, WB_X6HI = 12, TL_X6HI = 17, X6HI_W = 4;
    localparam int HALF_W = 16, X4_HI = 16, X5_HI = 16, X5HI_W = 8;
    localparam int WB_X6MID = 8, TL_X6MID = 21, X6MID_W = 3, WB_BUF = 11, BUF_LSB = 16;
    localparam int DELTA_LSB = 20, DELTA_W = 2, NUM_DELTA = 6, WB_MAC = 12, MAC_LSB = 26;
    localparam int MAC_W = 4, FTS_W = 8, WB_DSK = 8, DSK_LSB = 13, FLD2_W = 2;
    localparam int WB_SCR = 10, SCR_LSB = 8, WB_L0S = 12, L0S_BIT = 10;
    localparam int WB_SPD = 13, SPD_LSB = 12, SPD_EN = 14, P2HI_LSB = 16, P2HI_W = 15;
    localparam int P2MID_LSB = 8, WB_P3 = 5, P3_W = 7, P3_LSB = 0;
    localparam int WB_DEEMPH = 12, DEEMPH_BIT = 6, WB_C2D = 13, C2D_BIT = 11;

    // software registers of the loader itself
    localparam logic [AVM_AW-1:0] A_CTRL   = 11'h400;
    localparam logic [AVM_AW-1:0] A_STATUS = 11'h404;
    localparam int CTRL_RELOAD = 0, ST_BUSY = 0, ST_DONE = 1, ST_IDX_LSB = 8;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_REQ   = 3'b001,
        ST_WAIT  = 3'b010,
        ST_APPLY = 3'b011,
        ST_FIN   = 3'b100
    } pwl_state_t;

    typedef logic [NUM_PORTS-1:0][NUM_REGS-1:0][31:0] pwl_cfg_t;

    typedef struct packed {
        logic              read;
        logic              write;
        logic [AVM_AW-1:0] address;
        logic [31:0]       writedata;
        logic [3:0]        byteenable;
    } pwl_avm_t;

    typedef struct packed {
        logic        req;
        logic [7:0]  addr;
    } pwl_store_req_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } pwl_store_rsp_t;

endpackage

// File: design/pwl_word_fetch.sv
// single-word read handshake towards the configuration word store
`timescale 1ns/10ps
module pwl_word_fetch (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    rstn,
    // loader side
    input  wire logic                    go,
    input  wire logic [7:0]              go_addr,
    output logic                         done,
    output logic [15:0]                  data,
    // store side
    output pwl_pkg::pwl_store_req_t      store_req,
    input  wire pwl_pkg::pwl_store_rsp_t store_rsp
);
    import pwl_pkg::*;

    typedef struct packed {
        pwl_store_req_t req;
        logic           done;
        logic [15:0]    data;
    } pwl_fetch_t;

    pwl_fetch_t st;
    pwl_fetch_t next_st;

    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        if (go && !st.req.req) begin
            next_st.req.req  = 1'b1;
            next_st.req.addr = go_addr;
        end
        // request stays up until the store answers; a slow store only stalls
        if (st.req.req && store_rsp.valid) begin
            next_st.req.req = 1'b0;
            next_st.done    = 1'b1;
            next_st.data    = store_rsp.data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign store_req = st.req;
    assign done      = st.done;
    assign data      = st.data;
endmodule

// File: design/pwl_avmm_slave.sv
// avalon-mm slave handshake: one wait cycle, then completion
`timescale 1ns/10ps
module pwl_avmm_slave (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rstn,
    // bus
    input  wire pwl_pkg::pwl_avm_t avm,
    output logic                   waitrequest,
    output logic [31:0]            readdata,
    // register file side
    input  wire logic [31:0]       rd_word,
    output logic                   wr_stb
);
    import pwl_pkg::*;

    typedef struct packed {
        logic        waitreq;
        logic [31:0] rdata;
    } pwl_slv_t;

    pwl_slv_t st;
    pwl_slv_t next_st;

    always_comb begin
        next_st = st;
        next_st.waitreq = 1'b1;
        if ((avm.read || avm.write) && st.waitreq) begin
            next_st.waitreq = 1'b0;
            if (avm.read) begin
                next_st.rdata = rd_word;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            st <= '{waitreq: 1'b1, rdata: 32'h0000_0000};
        end else begin
            st <= next_st;
        end
    end

    assign waitrequest = st.waitreq;
    assign readdata    = st.rdata;
    // the write lands at the edge where the master sees waitrequest low
    assign wr_stb      = avm.write && !st.waitreq;
endmodule

// File: design/pwl_loader.sv
// phy word configuration loader: word store to per-port configuration registers
//
// Behaviour
// - word 0Eh three 5-bit fields go to 94h [14:0], ports 0-2
// - word 0Eh bit 15 sets 94h-side capability bit E4h[18], ports 0-2
// - word 10h three 5-bit fields go to 74h [30:16], ports 0-2
// - word 10h bit 15 goes to 8Ch bit 31, ports 0-2
// - word 12h three 5-bit fields go to 78h [30:16], ports 0-2
// - word 12h bit 15 goes to 8Ch bit 16, ports 0-2
// - word 14h [3:0] to 7Ch [3:0], [6:4] to 7Ch [6:4], ports 0-2
// - word 14h [11:7] to 90h [19:15], [15:12] to 8Ch [20:17]
// - word 1Ah to 88h [15:0], word 1Ch [7:0] to 88h [23:16]
// - word 1Ch [10:8] to 8Ch [23:21], [15:11] to 98h [20:16]
// - word 1Eh six 2-bit fields go to 90h [31:20], ports 0-2
// - word 1Eh [15:12] goes to 8Ch [29:26], ports 0-2
// - words 20h-26h serve ports 0-3; [7:0] to 78h [7:0]
// - per-port word [9:8] goes to 68h [14:13] of that port
// - per-port word [11:10] to 78h [9:8], bit 12 to 78h bit 10
// - per-port word [14:13] to 78h [13:12], bit 15 to 78h bit 14
// - words 30h-36h [14:0] go to 7Ch [30:16] of ports 0-3
// - word 40h [4:0] to port 0 7Ch [12:8], [11:5] to 90h [6:0]
// - word 40h bit 12 goes to port 0 F0h bit 6
// - word 40h bit 13 goes to port 0 78h bit 11
`timescale 1ns/10ps
module pwl_loader (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    rstn,
    // register bus
    input  wire pwl_pkg::pwl_avm_t       avm,
    output logic                         waitrequest,
    output logic [31:0]                  readdata,
    // word store
    output pwl_pkg::pwl_store_req_t      store_req,
    input  wire pwl_pkg::pwl_store_rsp_t store_rsp,
    // port configuration
    output pwl_pkg::pwl_cfg_t            cfg_out,
    output logic                         ports_release
);
    import pwl_pkg::*;

    localparam logic [4:0] LAST_IDX = 5'(NUM_WORDS - 1);

    typedef struct packed {
        pwl_state_t  state;
        logic [4:0]  idx;
        logic [7:0]  waddr;
        logic [15:0] wdata;
        logic        fetch_go;
        logic        pend;
        logic        busy;
        logic        done;
        pwl_cfg_t    cfg;
    } pwl_core_t;

    pwl_core_t   st;
    pwl_core_t   next_st;
    logic        fetch_done;
    logic [15:0] fetch_data;
    logic        wr_stb;
    logic [31:0] rd_word;

    function automatic logic [31:0] put(logic [31:0] r, int lsb, int w, logic [31:0] v);
        logic [31:0] m;
        m = ((32'h1 << w) - 32'h1) << lsb;
        put = (r & ~m) | ((v << lsb) & m);
    endfunction

    function automatic logic [31:0] get(logic [15:0] d, int wb);
        get = {16'h0000, d} >> wb;
    endfunction

    // load order: common words, per-port words, second phy words, port 0 word
    function automatic logic [7:0] seq_addr(logic [4:0] i);
        logic [7:0] k;
        k = {3'b000, i};
        if (i < 5'(SEQ_COMMON)) begin
            seq_addr = W_MARGIN + WORD_STEP * k;
        end else if (i < 5'(SEQ_COMMON + SEQ_PORT)) begin
            seq_addr = W_PORT_BASE + WORD_STEP * (k - 8'(SEQ_COMMON));
        end else if (i < 5'(SEQ_COMMON + 2 * SEQ_PORT)) begin
            seq_addr = W_P2_BASE + WORD_STEP * (k - 8'(SEQ_COMMON + SEQ_PORT));
        end else begin
            seq_addr = W_PORT0;
        end
    endfunction

    // only the fields a word names are touched, the rest keep their value
    function automatic pwl_cfg_t apply_word(pwl_cfg_t c, logic [7:0] a, logic [15:0] d);
        pwl_cfg_t   r;
        logic [1:0] pp;
        r = c;
        pp = 2'(a[7:1] - W_PORT_BASE[7:1]);
        if (a >= W_PORT_BASE && a <= W_PORT_LAST) begin
            r[pp][I_PHY1] = put(r[pp][I_PHY1], 0, FTS_W, get(d, WB_LO));
            r[pp][I_DESKEW] = put(r[pp][I_DESKEW], DSK_LSB, FLD2_W, get(d, WB_DSK));
            r[pp][I_PHY1] = put(r[pp][I_PHY1], SCR_LSB, FLD2_W, get(d, WB_SCR));
            r[pp][I_PHY1] = put(r[pp][I_PHY1], L0S_BIT, 1, get(d, WB_L0S));
            r[pp][I_PHY1] = put(r[pp][I_PHY1], SPD_LSB, FLD2_W, get(d, WB_SPD));
            r[pp][I_PHY1] = put(r[pp][I_PHY1], SPD_EN, 1, get(d, WB_TOP));
        end else if (a >= W_P2_BASE && a <= W_P2_LAST) begin
            pp = 2'(a[7:1] - W_P2_BASE[7:1]);
            r[pp][I_PHY2] = put(r[pp][I_PHY2], P2HI_LSB, P2HI_W, get(d, WB_LO));
        end else if (a == W_PORT0) begin
            r[0][I_PHY2] = put(r[0][I_PHY2], P2MID_LSB, DRV_W, get(d, WB_LO));
            r[0][I_PHY3] = put(r[0][I_PHY3], P3_LSB, P3_W, get(d, WB_P3));
            r[0][I_DEEMPH] = put(r[0][I_DEEMPH], DEEMPH_BIT, 1, get(d, WB_DEEMPH));
            r[0][I_PHY1] = put(r[0][I_PHY1], C2D_BIT, 1, get(d, WB_C2D));
        end else begin
            // common words reach ports 0 to 2 only
            for (int p = 0; p < NUM_PORTS - 1; p++) begin
                case (a)
                    W_MARGIN: begin
                        r[p][I_MARGIN] = put(r[p][I_MARGIN], 0, 3 * DRV_W, get(d, WB_LO));
                        r[p][I_CAP] = put(r[p][I_CAP], CAP_OBFF, 1, get(d, WB_TOP));
                    end
                    W_PHY0: begin
                        r[p][I_PHY0] = put(r[p][I_PHY0], NOM_LSB, 3 * DRV_W, get(d, WB_LO));
                        r[p][I_TLCTRL] = put(r[p][I_TLCTRL], TL_GEN2, 1, get(d, WB_TOP));
                    end
                    W_PHY1: begin
                        r[p][I_PHY1] = put(r[p][I_PHY1], EMP_LSB, 3 * DRV_W, get(d, WB_LO));
                        r[p][I_TLCTRL] = put(r[p][I_TLCTRL], TL_X6B0, 1, get(d, WB_TOP));
                    end
                    W_PHY2: begin
                        r[p][I_PHY2] = put(r[p][I_PHY2], LAT_LSB, LAT_W, get(d, WB_LO));
                        r[p][I_PHY2] = put(r[p][I_PHY2], RXDET_LSB, RXDET_W, get(d, RXDET_LSB));
                        r[p][I_PHY3] = put(r[p][I_PHY3], HALFD_LSB, DRV_W, get(d, WB_HALFD));
                        r[p][I_TLCTRL] = put(r[p][I_TLCTRL], TL_X6HI, X6HI_W, get(d, WB_X6HI));
                    end
                    W_X4LO: begin
                        r[p][I_XPORT4] = put(r[p][I_XPORT4], 0, HALF_W, get(d, WB_LO));
                    end
                    W_X4HI: begin
                        r[p][I_XPORT4] = put(r[p][I_XPORT4], X4_HI, HALF_W, get(d, WB_LO));
                    end
                    W_X5LO: begin
                        r[p][I_XPORT5] = put(r[p][I_XPORT5], 0, HALF_W, get(d, WB_LO));
                    end
                    W_X5HI: begin
                        r[p][I_XPORT5] = put(r[p][I_XPORT5], X5_HI, X5HI_W, get(d, WB_LO));
                        r[p][I_TLCTRL] = put(r[p][I_TLCTRL], TL_X6MID, X6MID_W, get(d, WB_X6MID));
                        r[p][I_BUFCTL] = put(r[p][I_BUFCTL], BUF_LSB, DRV_W, get(d, WB_BUF));
                    end
                    W_DELTA: begin
                        for (int k = 0; k < NUM_DELTA; k++) begin
                            r[p][I_PHY3] = put(r[p][I_PHY3], DELTA_LSB + DELTA_W * k, DELTA_W,
                                               get(d, DELTA_W * k));
                        end
                        r[p][I_TLCTRL] = put(r[p][I_TLCTRL], MAC_LSB, MAC_W, get(d, WB_MAC));
                    end
                    default: begin
                        r[p] = r[p];
                    end
                endcase
            end
        end
        apply_word = r;
    endfunction

    function automatic int reg_index(logic [7:0] ofs);
        case (ofs)
            OFS_DESKEW: reg_index = I_DESKEW;
            OFS_PHY0:   reg_index = I_PHY0;
            OFS_PHY1:   reg_index = I_PHY1;
            OFS_PHY2:   reg_index = I_PHY2;
            OFS_XPORT4: reg_index = I_XPORT4;
            OFS_XPORT5: reg_index = I_XPORT5;
            OFS_TLCTRL: reg_index = I_TLCTRL;
            OFS_PHY3:   reg_index = I_PHY3;
            OFS_MARGIN: reg_index = I_MARGIN;
            OFS_BUFCTL: reg_index = I_BUFCTL;
            OFS_CAP:    reg_index = I_CAP;
            OFS_DEEMPH: reg_index = I_DEEMPH;
            default:    reg_index = -1;
        endcase
    endfunction

    // read view: per-port windows below A_CTRL, loader registers above
    always_comb begin
        int ri;
        ri = reg_index(avm.address[7:0]);
        rd_word = 32'h0000_0000;
        if (avm.address == A_STATUS) begin
            rd_word[ST_BUSY] = st.busy;
            rd_word[ST_DONE] = st.done;
            rd_word[ST_IDX_LSB +: 5] = st.idx;
        end else if (!avm.address[AVM_AW-1] && ri >= 0) begin
            rd_word = st.cfg[avm.address[9:8]][ri];
        end
    end

    always_comb begin
        next_st = st;
        next_st.fetch_go = 1'b0;
        case (st.state)
            ST_IDLE: begin
                if (st.pend) begin
                    next_st.pend  = 1'b0;
                    next_st.idx   = 5'h00;
                    next_st.busy  = 1'b1;
                    next_st.done  = 1'b0;
                    next_st.state = ST_REQ;
                end
            end
            ST_REQ: begin
                next_st.waddr    = seq_addr(st.idx);
                next_st.fetch_go = 1'b1;
                next_st.state    = ST_WAIT;
            end
            ST_WAIT: begin
                if (fetch_done) begin
                    next_st.wdata = fetch_data;
                    next_st.state = ST_APPLY;
                end
            end
            ST_APPLY: begin
                next_st.cfg = apply_word(st.cfg, st.waddr, st.wdata);
                if (st.idx == LAST_IDX) begin
                    next_st.state = ST_FIN;
                end else begin
                    next_st.idx   = st.idx + 5'h01;
                    next_st.state = ST_REQ;
                end
            end
            ST_FIN: begin
                next_st.busy  = 1'b0;
                next_st.done  = 1'b1;
                next_st.state = ST_IDLE;
            end
            default: begin
                next_st.state = ST_IDLE;
            end
        endcase
        // a reload during a load is ignored so that no field sees two words
        // placed after the state logic so a set meeting the start-of-load clear wins
        if (wr_stb && avm.address == A_CTRL && avm.byteenable[0] &&
            avm.writedata[CTRL_RELOAD] && !st.busy) begin
            next_st.pend = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            st      <= '0;
            st.pend <= 1'b1;
            st.cfg  <= {(NUM_PORTS * NUM_REGS){CFG_RESET}};
        end else begin
            st <= next_st;
        end
    end

    pwl_word_fetch u_fetch (
        .clk       (clk),
        .rstn      (rstn),
        .go        (st.fetch_go),
        .go_addr   (st.waddr),
        .done      (fetch_done),
        .data      (fetch_data),
        .store_req (store_req),
        .store_rsp (store_rsp)
    );

    pwl_avmm_slave u_slave (
        .clk         (clk),
        .rstn        (rstn),
        .avm         (avm),
        .waitrequest (waitrequest),
        .readdata    (readdata),
        .rd_word     (rd_word),
        .wr_stb      (wr_stb)
    );

    assign cfg_out       = st.cfg;
    assign ports_release = st.done;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_apply(logic [7:0] a);
        st.state == ST_APPLY && st.waddr == a;
    endsequence

    a_margin_copy: assert property (s_apply(W_MARGIN) |=>
        st.cfg[0][I_MARGIN][14:0] == st.wdata[14:0] && st.cfg[2][I_MARGIN][14:0] == st.wdata[14:0])
        else $error("margin drive levels not copied");
    a_obff_copy: assert property (s_apply(W_MARGIN) |=> st.cfg[1][I_CAP][18] == st.wdata[15])
        else $error("obff enable not copied");
    a_nominal_drive: assert property (s_apply(W_PHY0) |=>
        st.cfg[1][I_PHY0][30:16] == st.wdata[14:0])
        else $error("nominal drive levels not copied");
    a_gen2_flag: assert property (s_apply(W_PHY0) |=> st.cfg[2][I_TLCTRL][31] == st.wdata[15])
        else $error("second gen flag not copied");
    a_fts_port: assert property ((st.state == ST_APPLY && st.waddr >= W_PORT_BASE &&
        st.waddr <= W_PORT_LAST) |=>
        st.cfg[2'(st.waddr[7:1] - W_PORT_BASE[7:1])][I_PHY1][7:0] == st.wdata[7:0])
        else $error("fts count went to wrong port");
    a_phy2_high: assert property ((st.state == ST_APPLY && st.waddr == W_P2_LAST) |=>
        st.cfg[3][I_PHY2][30:16] == st.wdata[14:0])
        else $error("port 3 phy parameter not copied");
    a_port0_deemph: assert property (s_apply(W_PORT0) |=>
        st.cfg[0][I_DEEMPH][6] == st.wdata[12] && st.cfg[1][I_DEEMPH] == CFG_RESET)
        else $error("de-emphasis select misplaced");
    a_untouched_hold: assert property (st.cfg[3][I_MARGIN] == CFG_RESET &&
        st.cfg[3][I_CAP] == CFG_RESET)
        else $error("untargeted register changed");
    a_release_last: assert property ((st.state == ST_APPLY && st.idx == LAST_IDX) |=>
        (st.state == ST_FIN && !ports_release) ##1 ports_release)
        else $error("ports released at wrong time");
    a_busy_hold: assert property (st.busy |-> !ports_release)
        else $error("ports released during load");
    a_fetch_take: assert property (fetch_done && st.state == ST_WAIT |=>
        st.state == ST_APPLY && st.wdata == $past(fetch_data))
        else $error("store word not taken");
    // remaining common words except 16h and 1Ah, and the port 0 word, land in their fields
    a_emph_nominal: assert property (s_apply(W_PHY1) |=>
        st.cfg[0][I_PHY1][30:16] == st.wdata[14:0])
        else $error("nominal emphasis not copied");
    a_x6_bit0: assert property (s_apply(W_PHY1) |=>
        st.cfg[1][I_TLCTRL][16] == st.wdata[15])
        else $error("phy control bit not copied");
    a_phy_latency: assert property (s_apply(W_PHY2) |=>
        st.cfg[2][I_PHY2][6:0] == st.wdata[6:0])
        else $error("latency or detect time not copied");
    a_half_delta: assert property (s_apply(W_PHY2) |=>
        st.cfg[0][I_PHY3][19:15] == st.wdata[11:7])
        else $error("half swing delta not copied");
    a_xport4_high: assert property (s_apply(W_X4HI) |=>
        st.cfg[1][I_XPORT4][31:16] == st.wdata)
        else $error("upper transport half not copied");
    a_bufctl_copy: assert property (s_apply(W_X5HI) |=>
        st.cfg[2][I_BUFCTL][20:16] == st.wdata[15:11])
        else $error("clock buffer control not copied");
    a_delta_pairs: assert property (s_apply(W_DELTA) |=>
        st.cfg[1][I_PHY3][31:20] == st.wdata[11:0])
        else $error("drive deltas not copied");
    a_mac_param: assert property (s_apply(W_DELTA) |=>
        st.cfg[2][I_TLCTRL][29:26] == st.wdata[15:12])
        else $error("mac parameter not copied");
    a_port0_phy: assert property (s_apply(W_PORT0) |=>
        st.cfg[0][I_PHY2][12:8] == st.wdata[4:0] && st.cfg[0][I_PHY3][6:0] == st.wdata[11:5])
        else $error("port 0 phy parameters not copied");
endmodule

// File: verification/pwl_store_model.sv
// behavioural word store answering after a selectable lag
`timescale 1ns/10ps
module pwl_store_model (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    rstn,
    // answer lag and store port
    input  wire logic [1:0]              lag,
    input  wire pwl_pkg::pwl_store_req_t store_req,
    output pwl_pkg::pwl_store_rsp_t      store_rsp
);
    import pwl_pkg::*;
    logic [15:0] mem [256];
    logic [1:0]  cnt;
    // data turns to its inverse after each answer, so a stale word never matches
    always_ff @(posedge clk) begin
        if (!rstn) begin
            store_rsp <= '0;
            cnt <= 2'h0;
        end else if (store_rsp.valid) begin
            store_rsp <= '{valid: 1'b0, data: ~store_rsp.data};
            cnt <= 2'h0;
        end else if (store_req.req && cnt >= lag) begin
            store_rsp <= '{valid: 1'b1, data: mem[store_req.addr]};
        end else if (store_req.req) begin
            cnt <= cnt + 2'h1;
        end
    end
endmodule

// File: verification/tb.sv
// self-checking bench of the configuration loader
`timescale 1ns/10ps
module tb;
    import pwl_pkg::*;
    logic clk, rstn, waitrequest, ports_release, prev_req = 1'b0;
    logic [1:0] lag;
    logic [31:0] readdata, q, lfsr = 32'h0001_838F;
    pwl_avm_t avm;
    pwl_store_req_t store_req;
    pwl_store_rsp_t store_rsp;
    pwl_cfg_t cfg_out;
    int fail_count = 0, checks_done = 0, k = 0;
    localparam logic [7:0] OFS [12] = '{OFS_DESKEW, OFS_PHY0, OFS_PHY1, OFS_PHY2, OFS_XPORT4,
        OFS_XPORT5, OFS_TLCTRL, OFS_PHY3, OFS_MARGIN, OFS_BUFCTL, OFS_CAP, OFS_DEEMPH};
    pwl_loader i_dut (.clk(clk), .rstn(rstn), .avm(avm), .waitrequest(waitrequest),
        .readdata(readdata), .store_req(store_req), .store_rsp(store_rsp),
        .cfg_out(cfg_out), .ports_release(ports_release));
    pwl_store_model i_store (.clk(clk), .rstn(rstn), .lag(lag), .store_req(store_req),
        .store_rsp(store_rsp));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    function automatic logic [15:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr[15:0];
    endfunction
    function automatic logic [31:0] exp_reg(int p, int i);
        logic [15:0] s [256];
        logic [31:0] r;
        logic [15:0] w;
        bit c;
        s = i_store.mem;
        r = CFG_RESET;
        c = (p < 3);
        w = s[W_PORT_BASE + 2 * p];
        case (i)
            I_DESKEW: r[14:13] = w[9:8];
            I_PHY0: if (c) r[30:16] = s[W_PHY0][14:0];
            I_PHY1: begin
                r[14:0] = {w[15:13], p == 0 && s[W_PORT0][13], w[12:10], w[7:0]};
                if (c) r[30:16] = s[W_PHY1][14:0];
            end
            I_PHY2: begin
                r[30:16] = s[W_P2_BASE + 2 * p][14:0];
                if (c) r[6:0] = s[W_PHY2][6:0];
                if (p == 0) r[12:8] = s[W_PORT0][4:0];
            end
            I_XPORT4: if (c) r = {s[W_X4HI], s[W_X4LO]};
            I_XPORT5: if (c) r[23:0] = {s[W_X5HI][7:0], s[W_X5LO]};
            I_TLCTRL: if (c) r = {s[W_PHY0][15], 1'b0, s[W_DELTA][15:12], 2'h0,
                s[W_X5HI][10:8], s[W_PHY2][15:12], s[W_PHY1][15], 16'h0};
            I_PHY3: begin
                if (c) r[31:15] = {s[W_DELTA][11:0], s[W_PHY2][11:7]};
                if (p == 0) r[6:0] = s[W_PORT0][11:5];
            end
            I_MARGIN: if (c) r[14:0] = s[W_MARGIN][14:0];
            I_BUFCTL: if (c) r[20:16] = s[W_X5HI][15:11];
            I_CAP: if (c) r[18] = s[W_MARGIN][15];
            I_DEEMPH: if (p == 0) r[6] = s[W_PORT0][12];
            default: ;
        endcase
        return r;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // bus master: hold the request until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [10:0] a, input logic [31:0] d);
        avm <= '{read: !wr, write: wr, address: a, writedata: d, byteenable: 4'hF};
        do begin
            @(posedge clk);
        end while (waitrequest !== 1'b0);
        q = readdata;
        avm <= '0;
        chk({31'h0, waitrequest}, 32'h0);
        @(posedge clk);
    endtask
    task automatic wait_load();
        while (ports_release !== 1'b1) @(posedge clk);
        chk({31'h0, ports_release}, 32'h1);
    endtask
    task automatic check_all(input bit loaded);
        for (int p = 0; p < NUM_PORTS; p++) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                chk(cfg_out[p][i], loaded ? exp_reg(p, i) : CFG_RESET);
                if (loaded) begin
                    bus(1'b0, {p[2:0], OFS[i]}, 32'h0);
                    chk(q, exp_reg(p, i));
                end
            end
        end
    endtask
    task automatic complete_run();
        $display("checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // fixed word order, and ports held back while words are still being fetched
    always @(posedge clk) begin
        prev_req <= store_req.req;
        if (!rstn) k <= 0;
        else if (store_req.req && !prev_req) begin
            chk({24'h0, store_req.addr}, k < 13 ? 14 + 2 * k : k < 17 ? 22 + 2 * k : 64);
            chk({31'h0, ports_release}, 32'h0);
            k <= (k == 17) ? 0 : k + 1;
        end
    end
    initial begin
        #400000;
        fail_count++;
        complete_run();
    end
    initial begin
        rstn = 1'b0;
        avm = '0;
        lag = 2'h0;
        for (int a = 0; a < 256; a++) i_store.mem[a] = rnd();
        repeat (10) @(posedge clk);
        check_all(1'b0);
        rstn <= 1'b1;
        for (int r = 0; r < 3; r++) begin
            wait_load();
            bus(1'b1, 11'h078, {rnd(), rnd()});
            check_all(1'b1);
            bus(1'b0, 11'h500, 32'h0);
            chk(q, 32'h0);
            if (r < 2) begin
                for (int a = 0; a < 256; a++) i_store.mem[a] = rnd();
                lag <= (r == 0) ? 2'h3 : 2'(rnd());
                bus(1'b1, A_CTRL, 32'h1);
                bus(1'b0, A_STATUS, 32'h0);
                chk(q & 32'h3, 32'h1);
            end
            if (r == 1) begin
                repeat (40) @(posedge clk);
                rstn <= 1'b0;
                repeat (10) @(posedge clk);
                check_all(1'b0);
                rstn <= 1'b1;
            end
        end
        complete_run();
    end
endmodule
